// *** scc_capture_prescaler.sv ***
// input prescaler: several detected edges make one capture event
`timescale 1ns/1ps
`default_nettype none

module scc_capture_prescaler #(
  parameter int ICP_W = scc_pkg::ICP_W
) (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       clear,
  input  wire logic       edgeEvent,
  input  wire logic [1:0] divideCode,
  output logic            captureEvent
);

  logic [ICP_W-1:0] count_q;
  logic [ICP_W-1:0] count_d;
  logic [ICP_W-1:0] limit;

  // divide by 1, 2, 4 or 8
  assign limit        = ICP_W'((4'h1 << divideCode) - 4'h1);
  assign captureEvent = edgeEvent && !clear && (count_q == limit);
  assign count_d      = (clear || captureEvent) ? scc_pkg::ICP_RST :
                        edgeEvent ? ICP_W'(count_q + 1'b1) : count_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count_q <= scc_pkg::ICP_RST;
    end else begin
      count_q <= count_d;
    end
  end

endmodule

`default_nettype wire

// *** scc_core.sv ***
// single channel capture/compare unit with up counter, repetition and shadows
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - overflow update occurs once every repetition count plus one counter cycles
// - repetition counter decrements by one at each overflow, and reloads at an overflow where it is zero
// - update generate reloads repetition counter and issues an update event
// - capture copies counter into channel value, sets flag, irq if enabled
// - input is synchronised, then filtered, then edge detected
// - channel polarity picks rising or falling edge for capture
// - input prescaler turns several edges into one capture
// - nonzero source select means input mode, channel value writes ignored
// - capture while flag still set also sets overcapture flag
// - capture raises interrupt and dma request per their enables
// - channel generate raises interrupt or dma request directly
// - compare match sets, clears or toggles output and sets flag
// - compare control 0 hold, 1 high, 2 low, 3 toggle at match
// - codes 6 and 7 are pwm modes, period from reload, duty from value
// - pwm mode 0 with value above reload gives constant active output
// - pwm mode 0 with value zero gives constant inactive output
// - codes 4 and 5 force prepare signal inactive or active
// - shadow enable chooses buffered or immediate channel value writes
// - channel enable gates capture and drives the output
// - counter runs only while counter enable is set
// - counter counts zero to reload, restarts and signals overflow
// - update event loads repetition, reload and prescaler shadows
// - update disable suppresses update events
module scc_core #(
  parameter int CNT_W = scc_pkg::CNT_W,
  parameter int PSC_W = scc_pkg::PSC_W,
  parameter int REP_W = scc_pkg::REP_W
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire scc_pkg::scc_timer_cfg_t timerCfg,
  input  wire scc_pkg::scc_chan_cfg_t  chanCfg,
  input  wire logic                   updateGenerate,
  input  wire logic                   channelGenerate,
  input  wire logic                   channelValueWrite,
  input  wire logic [CNT_W-1:0]       channelValueData,
  input  wire logic                   channelFlagClear,
  input  wire logic                   overcaptureFlagClear,
  input  wire logic                   channelInput,
  output logic [CNT_W-1:0]            counterValue,
  output logic [REP_W-1:0]            repetitionCounter,
  output logic [CNT_W-1:0]            channelValue,
  output logic                        channelFlag,
  output logic                        overcaptureFlag,
  output logic                        channelIrq,
  output logic                        channelDmaReq,
  output logic                        updateEvent,
  output logic                        outputPrepare,
  output logic                        channelOut,
  output logic                        channelOutEnable
);

  // ********************************
  // state
  // ********************************
  logic [CNT_W-1:0] counter_q;
  logic [CNT_W-1:0] counter_d;
  logic [PSC_W-1:0] pscCnt_q;
  logic [PSC_W-1:0] pscCnt_d;
  logic [PSC_W-1:0] pscShadow_q;
  logic [CNT_W-1:0] arShadow_q;
  logic [REP_W-1:0] repShadow_q;
  logic [REP_W-1:0] repCnt_q;
  logic [REP_W-1:0] repCnt_d;
  logic [CNT_W-1:0] cvReg_q;
  logic [CNT_W-1:0] cvReg_d;
  logic [CNT_W-1:0] cmpShadow_q;
  logic             eqPrev_q;
  logic             flag_q;
  logic             ovcap_q;
  logic             irq_q;
  logic             dma_q;
  logic             update_q;
  logic             prep_q;
  logic             prep_d;
  logic             out_q;
  logic             oe_q;

  // ********************************
  // counter and repetition decode
  // ********************************
  wire tick       = timerCfg.counterEnable && (pscCnt_q == pscShadow_q);
  wire overflow   = tick && (counter_q == arShadow_q);
  wire repZero    = (repCnt_q == scc_pkg::REP_RST);
  wire updateEvt  = ((overflow && repZero) || updateGenerate) && !timerCfg.updateDisable;

  assign pscCnt_d  = updateGenerate ? scc_pkg::PSC_RST :
                     tick ? scc_pkg::PSC_RST :
                     timerCfg.counterEnable ? PSC_W'(pscCnt_q + 1'b1) : pscCnt_q;
  assign counter_d = (updateGenerate || overflow) ? scc_pkg::CNT_RST :
                     tick ? CNT_W'(counter_q + 1'b1) : counter_q;
  assign repCnt_d  = updateEvt ? timerCfg.repetitionCount :
                     (overflow && repZero) ? repShadow_q :
                     overflow ? REP_W'(repCnt_q - 1'b1) : repCnt_q;

  // ********************************
  // input path
  // ********************************
  wire inputMode = (chanCfg.captureSourceSelect != scc_pkg::SRC_OUTPUT);
  wire capActive = inputMode && chanCfg.channelEnable;
  wire riseEdge;
  wire fallEdge;
  wire filtLevel;
  wire capEvent;

  scc_input_filter #(
    .FLT_W (scc_pkg::FLT_W)
  ) u_filter (
    .clk_sys       (clk_sys),
    .reset         (reset),
    .channelInput  (channelInput),
    .filterSetting (chanCfg.captureFilterSetting),
    .filtered      (filtLevel),
    .riseEdge      (riseEdge),
    .fallEdge      (fallEdge)
  );

  // polarity clear selects the rising edge
  wire selEdge = (chanCfg.channelPolarity == scc_pkg::POL_RISING) ? riseEdge : fallEdge;

  scc_capture_prescaler #(
    .ICP_W (scc_pkg::ICP_W)
  ) u_prescale (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .clear        (!capActive),
    .edgeEvent    (selEdge),
    .divideCode   (chanCfg.capturePrescale),
    .captureEvent (capEvent)
  );

  // ********************************
  // channel value and compare
  // ********************************
  // software writes only land in output mode; capture owns the register otherwise
  assign cvReg_d = capEvent ? counter_q :
                   (channelValueWrite && !inputMode) ? channelValueData : cvReg_q;

  // buffered value follows the register at update, or continuously when unbuffered
  wire [CNT_W-1:0] cmpActive = chanCfg.compareShadowEnable ? cmpShadow_q : cvReg_q;
  wire             cmpEqual  = !inputMode && (counter_q == cmpActive);
  wire             matchEvt  = cmpEqual && !eqPrev_q && timerCfg.counterEnable;
  wire             pwmBelow  = (counter_q < cmpActive);
  wire             chanEvt   = capEvent || matchEvt || channelGenerate;

  always_comb begin
    prep_d = prep_q;
    unique case (chanCfg.compareControl)
      scc_pkg::CMP_FROZEN:     prep_d = prep_q;
      scc_pkg::CMP_SET:        prep_d = matchEvt ? 1'b1 : prep_q;
      scc_pkg::CMP_CLEAR:      prep_d = matchEvt ? 1'b0 : prep_q;
      scc_pkg::CMP_TOGGLE:     prep_d = matchEvt ? !prep_q : prep_q;
      scc_pkg::CMP_FORCE_LOW:  prep_d = 1'b0;
      scc_pkg::CMP_FORCE_HIGH: prep_d = 1'b1;
      scc_pkg::CMP_PWM0:       prep_d = pwmBelow;
      scc_pkg::CMP_PWM1:       prep_d = !pwmBelow;
    endcase
  end

  wire drvOut = chanCfg.channelEnable && !inputMode;

  // ********************************
  // timer registers
  // ********************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      counter_q   <= scc_pkg::CNT_RST;
      pscCnt_q    <= scc_pkg::PSC_RST;
      pscShadow_q <= scc_pkg::PSC_RST;
      arShadow_q  <= scc_pkg::CNT_RST;
      repShadow_q <= scc_pkg::REP_RST;
      repCnt_q    <= scc_pkg::REP_RST;
      update_q    <= 1'b0;
    end else begin
      counter_q <= counter_d;
      pscCnt_q  <= pscCnt_d;
      repCnt_q  <= repCnt_d;
      update_q  <= updateEvt;
      if (updateEvt) begin
        pscShadow_q <= timerCfg.prescaler;
        arShadow_q  <= timerCfg.autoReload;
        repShadow_q <= timerCfg.repetitionCount;
      end
    end
  end

  // ********************************
  // channel registers
  // ********************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cvReg_q     <= scc_pkg::CNT_RST;
      cmpShadow_q <= scc_pkg::CNT_RST;
      eqPrev_q    <= 1'b0;
      prep_q      <= 1'b0;
      out_q       <= 1'b0;
      oe_q        <= 1'b0;
    end else begin
      cvReg_q  <= cvReg_d;
      eqPrev_q <= cmpEqual;
      prep_q   <= prep_d;
      out_q    <= drvOut && (prep_q ^ chanCfg.channelPolarity);
      oe_q     <= drvOut;
      if (updateEvt || !chanCfg.compareShadowEnable) begin
        cmpShadow_q <= cvReg_d;
      end
    end
  end

  // ********************************
  // flags and requests
  // ********************************
  // a set arriving with a clear wins, so no event is lost
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flag_q  <= 1'b0;
      ovcap_q <= 1'b0;
      irq_q   <= 1'b0;
      dma_q   <= 1'b0;
    end else begin
      if (chanEvt) begin
        flag_q <= 1'b1;
      end else if (channelFlagClear) begin
        flag_q <= 1'b0;
      end
      if (capEvent && flag_q) begin
        ovcap_q <= 1'b1;
      end else if (overcaptureFlagClear) begin
        ovcap_q <= 1'b0;
      end
      irq_q <= flag_q && chanCfg.channelIntEnable;
      dma_q <= chanEvt && chanCfg.channelDmaEnable;
    end
  end

  assign counterValue      = counter_q;
  assign repetitionCounter = repCnt_q;
  assign channelValue      = cvReg_q;
  assign channelFlag       = flag_q;
  assign overcaptureFlag   = ovcap_q;
  assign channelIrq        = irq_q;
  assign channelDmaReq     = dma_q;
  assign updateEvent       = update_q;
  assign outputPrepare     = prep_q;
  assign channelOut        = out_q;
  assign channelOutEnable  = oe_q;

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  AST_UPD_CAUSE: assert property (updateEvent |-> !$past(timerCfg.updateDisable)
                                  && ($past(updateGenerate) || $past(timerCfg.counterEnable
                                  && counter_q == arShadow_q && repCnt_q == scc_pkg::REP_RST)))
    else $error("update event without overflow at zero repetition");
  AST_REP_DEC: assert property (overflow && !repZero && !updateGenerate |=> repCnt_q == $past(repCnt_q) - 1'b1)
    else $error("repetition counter did not decrement");
  AST_UPG: assert property (updateGenerate && !timerCfg.updateDisable
                            |=> updateEvent && repCnt_q == $past(timerCfg.repetitionCount))
    else $error("update generate did not reload and update");
  AST_CAPTURE: assert property (capEvent |=> channelValue == $past(counter_q) && channelFlag)
    else $error("capture did not store counter and flag");
  AST_IN_LOCK: assert property (inputMode && !capEvent |=> $stable(cvReg_q))
    else $error("channel value changed in input mode without capture");
  AST_OVCAP: assert property (capEvent && flag_q |=> overcaptureFlag)
    else $error("overcapture flag not set");
  AST_IRQ: assert property (chanEvt && chanCfg.channelIntEnable ##1 chanCfg.channelIntEnable |=> channelIrq)
    else $error("interrupt missing after channel event");
  AST_GEN_DMA: assert property (channelGenerate && chanCfg.channelDmaEnable |=> channelDmaReq && channelFlag)
    else $error("generate produced no dma request");
  AST_TOGGLE: assert property (matchEvt && chanCfg.compareControl == scc_pkg::CMP_TOGGLE
                               |=> outputPrepare != $past(prep_q))
    else $error("toggle mode did not toggle at match");
  AST_PWM0_FULL: assert property (chanCfg.compareControl == scc_pkg::CMP_PWM0 && !inputMode
                                  && cmpActive > arShadow_q && counter_q <= arShadow_q |=> outputPrepare)
    else $error("pwm0 not held active above reload");
  AST_PWM0_ZERO: assert property (chanCfg.compareControl == scc_pkg::CMP_PWM0 && cmpActive == '0 |=> !outputPrepare)
    else $error("pwm0 not held inactive at zero");
  AST_PWM1: assert property (chanCfg.compareControl == scc_pkg::CMP_PWM1 && !inputMode
                             |=> outputPrepare == ($past(counter_q) >= $past(cmpActive)))
    else $error("pwm1 level does not follow the compare");
  AST_FORCE: assert property (chanCfg.compareControl == scc_pkg::CMP_FORCE_LOW [*2] |-> !outputPrepare)
    else $error("forced inactive level not held");
  AST_STOP: assert property (!timerCfg.counterEnable && !updateGenerate |=> $stable(counter_q))
    else $error("counter moved while disabled");
  AST_UPDATE_DISABLE: assert property (timerCfg.updateDisable |=> !updateEvent)
    else $error("update event while disabled");
  AST_OUT_GATE: assert property (!chanCfg.channelEnable |=> !channelOutEnable && !channelOut)
    else $error("output driven while channel disabled");

  COV_CAPTURE: cover property (capEvent ##[1:50] capEvent);
  COV_OVCAP: cover property (capEvent && flag_q);
  COV_REP_UPDATE: cover property (overflow && !repZero ##[1:200] overflow && repZero);
  COV_PWM: cover property (chanCfg.compareControl == scc_pkg::CMP_PWM1 && $rose(prep_q));

endmodule

`default_nettype wire

// *** scc_input_filter.sv ***
// input synchroniser, digital filter and edge detector of the channel input
`timescale 1ns/1ps
`default_nettype none

module scc_input_filter #(
  parameter int FLT_W = scc_pkg::FLT_W
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             channelInput,
  input  wire logic [FLT_W-1:0] filterSetting,
  output logic                  filtered,
  output logic                  riseEdge,
  output logic                  fallEdge
);

  logic             sync1_q;
  logic             sync2_q;
  logic             filt_q;
  logic             rise_q;
  logic             fall_q;
  logic [FLT_W-1:0] stable_q;
  logic [FLT_W-1:0] stable_d;
  logic             accept;

  // ********************************
  // filter: setting + 1 equal samples
  // ********************************
  assign accept   = (sync2_q != filt_q) && (stable_q == filterSetting);
  assign stable_d = (sync2_q == filt_q || accept) ? '0 : FLT_W'(stable_q + 1'b1);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync1_q  <= 1'b0;
      sync2_q  <= 1'b0;
      filt_q   <= 1'b0;
      rise_q   <= 1'b0;
      fall_q   <= 1'b0;
      stable_q <= '0;
    end else begin
      sync1_q  <= channelInput;
      sync2_q  <= sync1_q;
      stable_q <= stable_d;
      if (accept) begin
        filt_q <= sync2_q;
      end
      rise_q <= accept && sync2_q;
      fall_q <= accept && !sync2_q;
    end
  end

  assign filtered = filt_q;
  assign riseEdge = rise_q;
  assign fallEdge = fall_q;

endmodule

`default_nettype wire

// *** scc_pkg.sv ***
// shared constants and carrier types of the single channel capture/compare unit
package scc_pkg;

  // ********************************
  // widths
  // ********************************
  localparam int CNT_W = 16;
  localparam int PSC_W = 16;
  localparam int REP_W = 8;
  localparam int FLT_W = 4;
  localparam int ICP_W = 3;

  // ********************************
  // compare control encodings
  // ********************************
  localparam logic [2:0] CMP_FROZEN     = 3'h0;
  localparam logic [2:0] CMP_SET        = 3'h1;
  localparam logic [2:0] CMP_CLEAR      = 3'h2;
  localparam logic [2:0] CMP_TOGGLE     = 3'h3;
  localparam logic [2:0] CMP_FORCE_LOW  = 3'h4;
  localparam logic [2:0] CMP_FORCE_HIGH = 3'h5;
  localparam logic [2:0] CMP_PWM0       = 3'h6;
  localparam logic [2:0] CMP_PWM1       = 3'h7;

  // ********************************
  // channel selections
  // ********************************
  localparam logic [1:0] SRC_OUTPUT   = 2'h0;
  localparam logic       POL_RISING   = 1'b0;
  localparam logic [1:0] ICP_DIV1     = 2'h0;

  // ********************************
  // reset values
  // ********************************
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [PSC_W-1:0] PSC_RST = 16'h0000;
  localparam logic [REP_W-1:0] REP_RST = 8'h00;
  localparam logic [FLT_W-1:0] FLT_RST = 4'h0;
  localparam logic [ICP_W-1:0] ICP_RST = 3'h0;

  // ********************************
  // carriers
  // ********************************
  typedef struct packed {
    logic             counterEnable;
    logic             updateDisable;
    logic [CNT_W-1:0] autoReload;
    logic [PSC_W-1:0] prescaler;
    logic [REP_W-1:0] repetitionCount;
  } scc_timer_cfg_t;

  typedef struct packed {
    logic             channelPolarity;
    logic [1:0]       captureSourceSelect;
    logic [FLT_W-1:0] captureFilterSetting;
    logic [1:0]       capturePrescale;
    logic [2:0]       compareControl;
    logic             compareShadowEnable;
    logic             channelEnable;
    logic             channelIntEnable;
    logic             channelDmaEnable;
  } scc_chan_cfg_t;

endpackage

// *** scc_pulse_source.sv ***
// pulse source that stands on the channel pin
`timescale 1ns/1ps
`default_nettype none

module scc_pulse_source (
  input  wire logic       clk_sys,
  input  wire logic       fire,
  input  wire logic [7:0] width,
  output logic            channelInput
);
  logic [7:0] remain_q;

  initial remain_q = 8'h00;

  // pin driven low between pulses, high for width cycles after fire
  always @(posedge clk_sys) begin
    if (fire) begin
      remain_q <= width;
    end else if (remain_q != 8'h00) begin
      remain_q <= remain_q - 8'h01;
    end
  end

  assign channelInput = (remain_q != 8'h00);
endmodule

`default_nettype wire

// *** testbench.sv ***
// self-checking testbench of the single channel capture/compare unit
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  scc_pkg::scc_timer_cfg_t tc;
  scc_pkg::scc_chan_cfg_t cc;
  logic ug, cg, cvw, cfc, ofc, fire, pin;
  logic [15:0] cvd, cnt, cv, cap;
  logic [7:0] width, rep;
  logic flag, oflag, irq, dma, upd, prep, cout, coe;
  int n_fail = 0;
  int n_checks = 0;
  int k;
  int hi;
  logic [2:0] modes [8] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h3, 3'h5, 3'h4, 3'h6};
  logic expd [8] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  always #12.5 clk_sys = ~clk_sys;

  scc_core dut (.clk_sys(clk_sys), .reset(reset), .timerCfg(tc), .chanCfg(cc), .updateGenerate(ug),
    .channelGenerate(cg), .channelValueWrite(cvw), .channelValueData(cvd), .channelFlagClear(cfc),
    .overcaptureFlagClear(ofc), .channelInput(pin), .counterValue(cnt), .repetitionCounter(rep),
    .channelValue(cv), .channelFlag(flag), .overcaptureFlag(oflag), .channelIrq(irq),
    .channelDmaReq(dma), .updateEvent(upd), .outputPrepare(prep), .channelOut(cout),
    .channelOutEnable(coe));

  scc_pulse_source src (.clk_sys(clk_sys), .fire(fire), .width(width), .channelInput(pin));

  // ****************************************
  // helpers
  // ****************************************
  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // one-cycle strobe: 0 update, 1 generate, 2 flag clear, 3 both clears, 4 pin pulse
  task automatic strobe(input int which);
    case (which)
      0: ug = 1'b1;
      1: cg = 1'b1;
      2: cfc = 1'b1;
      3: begin
        cfc = 1'b1;
        ofc = 1'b1;
      end
      default: fire = 1'b1;
    endcase
    cyc(1);
    // lower only what this call raised, so a following strobe never rewrites it in the same step
    case (which)
      0: ug = 1'b0;
      1: cg = 1'b0;
      2: cfc = 1'b0;
      3: begin
        cfc = 1'b0;
        ofc = 1'b0;
      end
      default: fire = 1'b0;
    endcase
  endtask

  task automatic writeValue(input logic [15:0] v);
    cvw = 1'b1;
    cvd = v;
    cyc(1);
    cvw = 1'b0;
  endtask

  // bounded wait for a raised flag (sel 0) or update pulse (sel 1); returns cycles waited
  task automatic waitFor(input int sel, output int n);
    n = 0;
    do begin
      cyc(1);
      n++;
      if (n > 200) begin
        n_fail++;
        $display("Error at %0t: wait limit used up", $time);
        test_done();
      end
    end while ((sel == 0) ? (flag !== 1'b1) : (upd !== 1'b1));
  endtask

  task automatic countHigh(output int h);
    h = 0;
    repeat (10) begin
      cyc(1);
      if (prep === 1'b1) h++;
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    tc = '0;
    cc = '0;
    {ug, cg, cvw, cfc, ofc, fire} = 6'h00;
    cvd = 16'h0000;
    width = 8'h00;
    cyc(4);
    reset = 1'b0;
    chk(cnt, 16'h0000);
    chk({flag, oflag, coe, upd}, 16'h0000);
    // repetition: reload 2, repetition 1
    tc.autoReload = 16'h0002;
    tc.repetitionCount = 8'h01;
    tc.counterEnable = 1'b1;
    strobe(0);
    waitFor(1, k);
    waitFor(1, k);
    chk(k[15:0], 16'h0006);
    chk(rep, 16'h0001);
    cyc(3);
    chk(rep, 16'h0000);
    hi = 0;
    repeat (12) begin
      cyc(1);
      if (cnt > 16'h0002) hi++;
    end
    chk(hi[15:0], 16'h0000);
    tc.updateDisable = 1'b1;
    hi = 0;
    repeat (30) begin
      cyc(1);
      if (upd !== 1'b0) hi++;
    end
    chk(hi[15:0], 16'h0000);
    tc.updateDisable = 1'b0;
    tc.counterEnable = 1'b0;
    cyc(2);
    cap = cnt;
    cyc(10);
    chk(cnt, cap);
    // compare modes: reload 9, value 5
    tc = '{counterEnable: 1'b1, updateDisable: 1'b0, autoReload: 16'h0009, prescaler: 16'h0000,
           repetitionCount: 8'h00};
    cc.channelEnable = 1'b1;
    cc.channelIntEnable = 1'b1;
    cc.channelDmaEnable = 1'b1;
    strobe(0);
    writeValue(16'h0005);
    for (int i = 0; i < 7; i++) begin
      cc.compareControl = modes[i];
      strobe(2);
      waitFor(0, k);
      cyc(3);
      chk(prep, expd[i]);
      chk({coe, cout}, {1'b1, expd[i]});
      chk(irq, 16'h0001);
    end
    // pwm duty table
    for (int i = 0; i < 4; i++) begin
      cc.compareControl = (i == 1) ? scc_pkg::CMP_PWM1 : scc_pkg::CMP_PWM0;
      writeValue((i == 2) ? 16'h0000 : (i == 3) ? 16'h000c : 16'h0004);
      cyc(12);
      countHigh(hi);
      chk(hi[15:0], (i == 0) ? 16'h0004 : (i == 1) ? 16'h0006 : (i == 2) ? 16'h0000 : 16'h000a);
    end
    // buffered write waits for an update
    cc.compareShadowEnable = 1'b1;
    tc.updateDisable = 1'b1;
    writeValue(16'h0004);
    cyc(12);
    countHigh(hi);
    chk(hi[15:0], 16'h000a);
    tc.updateDisable = 1'b0;
    cyc(12);
    countHigh(hi);
    chk(hi[15:0], 16'h0004);
    // capture path
    tc.autoReload = 16'hffff;
    strobe(0);
    cc.captureSourceSelect = 2'h1;
    cc.captureFilterSetting = 4'h3;
    strobe(3);
    writeValue(16'h1234);
    chk(cv, 16'h0004);
    width = 8'h02;
    strobe(4);
    cyc(20);
    chk(flag, 16'h0000);
    width = 8'h08;
    strobe(4);
    hi = 0;
    for (int j = 0; j < 20; j++) begin
      cyc(1);
      if (dma === 1'b1) hi++;
    end
    chk({flag, irq}, 16'h0003);
    chk(hi[15:0], 16'h0001);
    strobe(4);
    cyc(20);
    chk(oflag, 16'h0001);
    strobe(3);
    cc.channelPolarity = 1'b1;
    tc.counterEnable = 1'b0;
    width = 8'h1e;
    strobe(4);
    cyc(15);
    chk(flag, 16'h0000);
    waitFor(0, k);
    cyc(1);
    chk(cv, cnt);
    cc.channelPolarity = 1'b0;
    cc.capturePrescale = 2'h1;
    cyc(20);
    strobe(2);
    width = 8'h08;
    strobe(4);
    cyc(20);
    chk(flag, 16'h0000);
    strobe(4);
    waitFor(0, k);
    // divide by four: only the fourth rising edge captures
    cc.capturePrescale = 2'h2;
    strobe(2);
    for (int j = 0; j < 4; j++) begin
      cyc(24);
      chk(flag, 16'h0000);
      strobe(4);
    end
    cyc(24);
    chk(flag, 16'h0001);
    strobe(2);
    cyc(2);
    strobe(1);
    cyc(2);
    chk(flag, 16'h0001);
    chk(irq, 16'h0001);
    test_done();
  end
endmodule

`default_nettype wire
